// *** rtl/frg_guard.sv ***
// Purpose: Flash rewrite protection and CPU rewrite mode control
// Assumes: Flash engine and programmer link run on clk; mode pins are async
// Notes: Commands are gated here, the flash engine does the array work
//
// Summary of operation
// - Parallel programmer blocked unless protect level field reads 11b.
// - Erasing the protect byte's block leaves it FFh.
// - Protect byte 00h or FFh means protection off.
// - Serial programmer commands refused on identification mismatch.
// - Blank reset vector FFFFFFFFh skips the identification check.
// - Seven identification bytes sit at fixed flash addresses.
// - CPU rewrite never programs or erases the boot area.
// - Flash commands accepted only with CPU rewrite enabled.
// - Variant select zero picks the RAM-resident variant.
// - ROM-resident variant refuses program or erase on routine block.
// - ROM-resident erase-all refused if routine unlocked or lock disabled.
// - Read-status command refused in the ROM-resident variant.
// - After an operation: read-status (RAM) or read-array (ROM) mode.
// - CPU held during ROM-resident operations only.
// - Ready and error bits in mode register and status register.
// - Rewrite enable forces block-A enable and area expansion to one.
// - Extended area unusable without expansion in large arrangement.
// - Variant select one, after enable, picks the ROM-resident variant.
// - Program error flag set on failed program, else zero.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module frg_guard
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire frg_pkg::frg_cmd_type cmd,
  input wire logic cmd_valid,
  output logic cmd_accept,
  output logic op_start,
  output frg_pkg::frg_cmd_type op_cmd,
  input wire logic op_done,
  input wire logic op_fail,
  input wire logic routine_unlocked,
  output logic read_mode_status,
  output logic cpu_hold,
  output logic block_a_en,
  output logic area_expand,
  input wire logic [19:0] ext_addr,
  output logic ext_blocked,
  input wire logic serial_mode_pin,
  input wire logic parallel_mode_pin,
  input wire logic large_map_pin,
  input wire logic par_req,
  output logic par_grant,
  input wire logic id_byte_valid,
  input wire logic [7:0] id_byte,
  input wire logic [55:0] id_stored,
  input wire logic [31:0] reset_vector,
  input wire logic prog_cmd_valid,
  output logic prog_cmd_accept
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] pin_reg;
  logic [2:0] pin_next;
  always_comb
  begin
    pin_next = pin_reg;
    for (int i = 0; i < 3; i++)
    begin
      if (s2_reg[i] == s3_reg[i])
      begin
        pin_next[i] = s3_reg[i];
      end
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
      pin_reg <= 3'h0;
    end
    else if (ce)
    begin
      s1_reg <= {large_map_pin, parallel_mode_pin, serial_mode_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
    end
  end
  logic serial_mode;
  logic parallel_mode;
  logic large_map;
  assign serial_mode = pin_reg[0];
  assign parallel_mode = pin_reg[1];
  assign large_map = pin_reg[2];

  // ****************************************
  // Control registers and sequencer
  // ****************************************
  frg_pkg::frg_state_type state_reg;
  frg_pkg::frg_state_type state_next;
  logic enable_reg;
  logic enable_next;
  logic en_arm_reg;
  logic en_arm_next;
  logic lock_dis_reg;
  logic lock_dis_next;
  logic ld_arm_reg;
  logic ld_arm_next;
  logic variant_reg;
  logic variant_next;
  logic var_arm_reg;
  logic var_arm_next;
  logic [3:0] routine_reg;
  logic [3:0] routine_next;
  logic block_a_reg;
  logic block_a_next;
  logic expand_reg;
  logic expand_next;
  logic prog_err_reg;
  logic prog_err_next;
  logic erase_err_reg;
  logic erase_err_next;
  logic [7:0] protect_reg;
  logic [7:0] protect_next;
  logic rstat_reg;
  logic rstat_next;
  logic start_reg;
  logic start_next;
  frg_pkg::frg_cmd_type opc_reg;
  frg_pkg::frg_cmd_type opc_next;
  logic hold_reg;
  logic hold_next;
  logic ext_reg;
  logic ext_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic busy;
  logic rom_variant;
  logic protect_active;
  logic [7:0] mode_a;
  logic [7:0] status_val;
  logic refuse;
  logic write_a;
  logic write_b;
  logic done_now;
  logic in_ext;
  logic id_ok;

  function automatic logic is_rewrite(input frg_pkg::frg_cmd_code_type c);
    is_rewrite = (c == frg_pkg::CMD_PROGRAM) || (c == frg_pkg::CMD_BLOCK_ERASE);
  endfunction

  assign busy = (state_reg == frg_pkg::ST_BUSY);
  assign rom_variant = enable_reg && variant_reg;
  assign done_now = busy && op_done;
  assign write_a = wr && (addr == frg_pkg::REG_MODE_A);
  assign write_b = wr && (addr == frg_pkg::REG_MODE_B);
  assign in_ext = (ext_addr >= frg_pkg::EXT_LO) && (ext_addr <= frg_pkg::EXT_HI);
  // Any level other than open, unless the byte reads blank or zero
  assign protect_active = (protect_reg[7:6] != frg_pkg::LEVEL_OPEN)
    && (protect_reg != frg_pkg::PROTECT_ZERO)
    && (protect_reg != frg_pkg::PROTECT_ERASED);
  assign par_grant = par_req && parallel_mode && !protect_active;
  assign prog_cmd_accept = prog_cmd_valid && serial_mode && id_ok;

  always_comb
  begin
    mode_a = 8'h00;
    mode_a[frg_pkg::MA_READY] = !busy;
    mode_a[frg_pkg::MA_ENABLE] = enable_reg;
    mode_a[frg_pkg::MA_LOCK_DIS] = lock_dis_reg;
    mode_a[frg_pkg::MA_PROG_ERR] = prog_err_reg;
    mode_a[frg_pkg::MA_ERASE_ERR] = erase_err_reg;
    status_val = 8'h00;
    status_val[frg_pkg::SR_READY] = !busy;
    status_val[frg_pkg::SR_ERASE_ERR] = erase_err_reg;
    status_val[frg_pkg::SR_PROG_ERR] = prog_err_reg;
  end

  always_comb
  begin
    refuse = !enable_reg || busy;
    if (is_rewrite(cmd.code) && cmd.boot_area)
    begin
      refuse = 1'b1;
    end
    if (rom_variant && is_rewrite(cmd.code) && cmd.block == routine_reg)
    begin
      refuse = 1'b1;
    end
    if (rom_variant && cmd.code == frg_pkg::CMD_ERASE_ALL
      && (routine_unlocked || lock_dis_reg))
    begin
      refuse = 1'b1;
    end
    if (rom_variant && cmd.code == frg_pkg::CMD_READ_STATUS)
    begin
      refuse = 1'b1;
    end
    if (cmd.code > frg_pkg::CMD_READ_ARRAY)
    begin
      refuse = 1'b1;
    end
  end
  assign cmd_accept = cmd_valid && !refuse;

  always_comb
  begin
    state_next = state_reg;
    enable_next = enable_reg;
    en_arm_next = en_arm_reg;
    lock_dis_next = lock_dis_reg;
    ld_arm_next = ld_arm_reg;
    variant_next = variant_reg;
    var_arm_next = var_arm_reg;
    routine_next = routine_reg;
    block_a_next = block_a_reg;
    expand_next = expand_reg;
    prog_err_next = prog_err_reg;
    erase_err_next = erase_err_reg;
    protect_next = protect_reg;
    rstat_next = rstat_reg;
    start_next = 1'b0;
    opc_next = opc_reg;
    rdata_next = 8'h00;
    if (write_a)
    begin
      // Zero then one arms each protected enable
      en_arm_next = !wdata[frg_pkg::MA_ENABLE];
      if (!wdata[frg_pkg::MA_ENABLE])
      begin
        enable_next = 1'b0;
        lock_dis_next = 1'b0;
        variant_next = 1'b0;
      end
      else if (en_arm_reg)
      begin
        enable_next = 1'b1;
      end
      ld_arm_next = !wdata[frg_pkg::MA_LOCK_DIS];
      if (!wdata[frg_pkg::MA_LOCK_DIS])
      begin
        lock_dis_next = 1'b0;
      end
      else if (ld_arm_reg && enable_reg)
      begin
        lock_dis_next = 1'b1;
      end
    end
    if (write_b)
    begin
      routine_next = wdata[frg_pkg::MB_ROUTINE_LSB +: 4];
      var_arm_next = !wdata[frg_pkg::MB_VARIANT];
      if (!wdata[frg_pkg::MB_VARIANT])
      begin
        variant_next = 1'b0;
      end
      else if (var_arm_reg && enable_reg)
      begin
        variant_next = 1'b1;
      end
    end
    if (wr && addr == frg_pkg::REG_PROC_B)
    begin
      // Held back from the outputs while rewrite is enabled
      block_a_next = wdata[frg_pkg::PB_BLOCK_A];
      expand_next = wdata[frg_pkg::PB_EXPAND];
    end
    if (wr && addr == frg_pkg::REG_PROTECT)
    begin
      protect_next = wdata;
    end
    if (rd)
    begin
      case (addr)
        frg_pkg::REG_MODE_A: rdata_next = mode_a;
        frg_pkg::REG_MODE_B: rdata_next = {routine_reg, 2'h0, variant_reg, 1'b0};
        frg_pkg::REG_PROC_B: rdata_next = {4'h0, expand_reg, 2'h0, block_a_reg};
        frg_pkg::REG_PROTECT: rdata_next = protect_reg;
        frg_pkg::REG_STATUS: rdata_next = rom_variant ? 8'h00 : status_val;
        default: rdata_next = 8'h00;
      endcase
    end
    case (state_reg)
      frg_pkg::ST_IDLE:
      begin
        if (cmd_accept)
        begin
          case (cmd.code)
            frg_pkg::CMD_READ_STATUS: rstat_next = 1'b1;
            frg_pkg::CMD_READ_ARRAY: rstat_next = 1'b0;
            frg_pkg::CMD_CLEAR_STATUS:
            begin
              prog_err_next = 1'b0;
              erase_err_next = 1'b0;
            end
            default:
            begin
              start_next = 1'b1;
              opc_next = cmd;
              state_next = frg_pkg::ST_BUSY;
            end
          endcase
        end
      end
      frg_pkg::ST_BUSY:
      begin
        if (op_done)
        begin
          state_next = frg_pkg::ST_IDLE;
          rstat_next = !rom_variant;
          if (opc_reg.code == frg_pkg::CMD_PROGRAM)
          begin
            prog_err_next = op_fail;
          end
          else
          begin
            erase_err_next = op_fail;
            if (!op_fail && (opc_reg.code == frg_pkg::CMD_ERASE_ALL
              || opc_reg.block == frg_pkg::PROTECT_BLOCK))
            begin
              protect_next = frg_pkg::PROTECT_ERASED;
            end
          end
        end
      end
      default: state_next = frg_pkg::ST_IDLE;
    endcase
    hold_next = (state_next == frg_pkg::ST_BUSY) && rom_variant;
    ext_next = in_ext && large_map && !(expand_reg || enable_reg);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= frg_pkg::ST_IDLE;
      enable_reg <= 1'b0;
      en_arm_reg <= 1'b0;
      lock_dis_reg <= 1'b0;
      ld_arm_reg <= 1'b0;
      variant_reg <= 1'b0;
      var_arm_reg <= 1'b0;
      routine_reg <= 4'h0;
      block_a_reg <= 1'b0;
      expand_reg <= 1'b0;
      prog_err_reg <= 1'b0;
      erase_err_reg <= 1'b0;
      protect_reg <= frg_pkg::PROTECT_RESET;
      rstat_reg <= 1'b0;
      start_reg <= 1'b0;
      opc_reg <= '0;
      hold_reg <= 1'b0;
      ext_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      enable_reg <= enable_next;
      en_arm_reg <= en_arm_next;
      lock_dis_reg <= lock_dis_next;
      ld_arm_reg <= ld_arm_next;
      variant_reg <= variant_next;
      var_arm_reg <= var_arm_next;
      routine_reg <= routine_next;
      block_a_reg <= block_a_next;
      expand_reg <= expand_next;
      prog_err_reg <= prog_err_next;
      erase_err_reg <= erase_err_next;
      protect_reg <= protect_next;
      rstat_reg <= rstat_next;
      start_reg <= start_next;
      opc_reg <= opc_next;
      hold_reg <= hold_next;
      ext_reg <= ext_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign op_start = start_reg;
  assign op_cmd = opc_reg;
  assign read_mode_status = rstat_reg;
  assign cpu_hold = hold_reg;
  assign ext_blocked = ext_reg;
  assign block_a_en = block_a_reg || enable_reg;
  assign area_expand = expand_reg || enable_reg;

  // ****************************************
  // Identification check
  // ****************************************
  frg_id_check u_id
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .enable(serial_mode),
    .byte_valid(id_byte_valid),
    .id_byte(id_byte),
    .id_stored(id_stored),
    .reset_vector(reset_vector),
    .id_ok(id_ok)
  );

  // ****************************************
  // Assertions
  // ****************************************
  a_cmd_needs_enable: assert property (@(posedge clk) disable iff (rst)
    cmd_accept |-> enable_reg) else $error("command taken while disabled");
  a_parallel_blocked: assert property (@(posedge clk) disable iff (rst)
    (protect_reg[7:6] != 2'h3 && protect_reg != 8'h00 && protect_reg != 8'hFF)
    |-> !par_grant) else $error("parallel access granted under protection");
  a_protect_off: assert property (@(posedge clk) disable iff (rst)
    (protect_reg == 8'h00 || protect_reg == 8'hFF) && par_req && parallel_mode
    |-> par_grant) else $error("blank protect byte still blocks");
  a_erase_sets_ff: assert property (@(posedge clk) disable iff (rst)
    ce && busy && op_done && !op_fail && opc_reg.code == frg_pkg::CMD_BLOCK_ERASE
    && opc_reg.block == 4'h0 |=> protect_reg == 8'hFF)
    else $error("protect byte not blank after erase");
  a_boot_refused: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && cmd.boot_area && is_rewrite(cmd.code) |-> !cmd_accept)
    else $error("boot area rewrite accepted");
  a_rom_no_status: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && rom_variant && cmd.code == frg_pkg::CMD_READ_STATUS
    |-> !cmd_accept) else $error("read status taken in rom variant");
  a_hold_rom_op: assert property (@(posedge clk) disable iff (rst)
    ce && cmd_accept && rom_variant && is_rewrite(cmd.code)
    |=> cpu_hold && op_start) else $error("cpu not held for rom operation");
  a_prog_err_flag: assert property (@(posedge clk) disable iff (rst)
    ce && busy && op_done && opc_reg.code == frg_pkg::CMD_PROGRAM
    |=> prog_err_reg == $past(op_fail)) else $error("program error flag wrong");
  a_mode_after_op: assert property (@(posedge clk) disable iff (rst)
    ce && busy && op_done |=> read_mode_status == !$past(rom_variant))
    else $error("wrong read mode after operation");
  a_enable_forces: assert property (@(posedge clk) disable iff (rst)
    enable_reg |-> block_a_en && area_expand) else $error("area bits not forced");
  a_id_reject: assert property (@(posedge clk) disable iff (rst)
    prog_cmd_valid && reset_vector != 32'hFFFFFFFF && !u_id.match_reg
    |-> !prog_cmd_accept) else $error("programmer command taken on mismatch");
endmodule // frg_guard

// *** rtl/frg_id_check.sv ***
// Purpose: Collects the programmer identification code and compares it
// Assumes: Bytes arrive on clk, first byte first
// Notes: A blank reset vector makes the check pass without bytes
`timescale 1ns/1ps
module frg_id_check
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic byte_valid,
  input wire logic [7:0] id_byte,
  input wire logic [55:0] id_stored,
  input wire logic [31:0] reset_vector,
  output logic id_ok
);
  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic [55:0] shift_reg;
  logic [55:0] shift_next;
  logic match_reg;
  logic match_next;
  // ****************************************
  // Collection and compare
  // ****************************************
  always_comb
  begin
    count_next = count_reg;
    shift_next = shift_reg;
    match_next = match_reg;
    if (!enable)
    begin
      count_next = 3'h0;
      match_next = 1'b0;
    end
    else if (byte_valid && count_reg < 3'(frg_pkg::ID_BYTES))
    begin
      // First byte lands in the low byte
      shift_next = {id_byte, shift_reg[55:8]};
      count_next = count_reg + 3'h1;
      if (count_reg == 3'(frg_pkg::ID_BYTES - 1))
      begin
        match_next = ({id_byte, shift_reg[55:8]} == id_stored);
      end
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_reg <= 3'h0;
      shift_reg <= 56'h0;
      match_reg <= 1'b0;
    end
    else if (ce)
    begin
      count_reg <= count_next;
      shift_reg <= shift_next;
      match_reg <= match_next;
    end
  end
  assign id_ok = match_reg || (reset_vector == frg_pkg::VECTOR_BLANK);
endmodule // frg_id_check

// *** rtl/frg_pkg.sv ***
// Purpose: Shared constants and types of the flash rewrite guard
// Assumes: Byte-wide register port, 4-bit register index
// Notes: Offsets are register indexes on the plain register port
package frg_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] REG_MODE_A = 4'h0;
  localparam logic [3:0] REG_MODE_B = 4'h1;
  localparam logic [3:0] REG_PROC_B = 4'h2;
  localparam logic [3:0] REG_PROTECT = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  // Mode A fields
  localparam int MA_READY = 0;
  localparam int MA_ENABLE = 1;
  localparam int MA_LOCK_DIS = 2;
  localparam int MA_PROG_ERR = 6;
  localparam int MA_ERASE_ERR = 7;
  localparam logic [7:0] MODE_A_RESET = 8'h01;
  // Mode B fields
  localparam int MB_VARIANT = 1;
  localparam int MB_ROUTINE_LSB = 4;
  // Processor mode B fields
  localparam int PB_BLOCK_A = 0;
  localparam int PB_EXPAND = 3;
  // Status register fields
  localparam int SR_READY = 7;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  // Protect byte
  localparam logic [7:0] PROTECT_RESET = 8'hFF;
  localparam logic [7:0] PROTECT_ERASED = 8'hFF;
  localparam logic [7:0] PROTECT_ZERO = 8'h00;
  localparam logic [1:0] LEVEL_OPEN = 2'h3;
  localparam logic [5:0] PROTECT_LOW_SET = 6'h3F;
  localparam logic [3:0] PROTECT_BLOCK = 4'h0;
  // Extended area in the large memory arrangement
  localparam logic [19:0] EXT_LO = 20'h40000;
  localparam logic [19:0] EXT_HI = 20'hBFFFF;
  // Identification code
  localparam int ID_BYTES = 7;
  localparam logic [31:0] VECTOR_BLANK = 32'hFFFFFFFF;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    CMD_PROGRAM = 3'h0,
    CMD_BLOCK_ERASE = 3'h1,
    CMD_ERASE_ALL = 3'h2,
    CMD_READ_STATUS = 3'h3,
    CMD_CLEAR_STATUS = 3'h4,
    CMD_READ_ARRAY = 3'h5
  } frg_cmd_code_type;
  typedef struct packed {
    frg_cmd_code_type code;
    logic [3:0] block;
    logic boot_area;
  } frg_cmd_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } frg_state_type;
endpackage

// *** sim/flash_rewrite_guard_and_cpu_rewrite_tb.sv ***
// Purpose: Self-checking bench of the flash rewrite guard
// Assumes: Engine model ends every started operation
// Notes: Register rows first, then hand-written cases
`timescale 1ns/1ps
module flash_rewrite_guard_and_cpu_rewrite_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  frg_pkg::frg_cmd_type cmd = '0;
  frg_pkg::frg_cmd_type op_cmd;
  logic cmd_valid = 1'b0;
  logic cmd_accept, op_start, op_done, op_fail, read_mode_status, cpu_hold;
  logic block_a_en, area_expand, ext_blocked, par_grant, prog_cmd_accept;
  logic fail_in = 1'b0;
  logic ce = 1'b1, large_pin = 1'b1, par_req = 1'b1, prog_valid = 1'b1;
  logic routine_unlocked = 1'b0;
  logic [19:0] ext_addr = 20'h00000;
  logic serial_pin = 1'b0;
  logic parallel_pin = 1'b1;
  logic id_valid = 1'b0;
  logic [7:0] id_byte = 8'h00;
  logic [31:0] vector = 32'h00001234;
  logic [7:0] delay = 8'h03;
  // Arbitrary identification value
  localparam logic [55:0] ID_VAL = 56'h13579BDF02468A;
  logic [3:0] row_addr [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};
  logic [7:0] row_val [5] = '{8'h01, 8'h00, 8'h00, 8'hFF, 8'h00};
  logic rom_on = 1'b0;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  always #4 clk = ~clk;
  frg_guard dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_accept(cmd_accept),
    .op_start(op_start), .op_cmd(op_cmd), .op_done(op_done), .op_fail(op_fail),
    .routine_unlocked(routine_unlocked), .read_mode_status(read_mode_status),
    .cpu_hold(cpu_hold), .block_a_en(block_a_en), .area_expand(area_expand),
    .ext_addr(ext_addr), .ext_blocked(ext_blocked), .serial_mode_pin(serial_pin),
    .parallel_mode_pin(parallel_pin), .large_map_pin(large_pin), .par_req(par_req),
    .par_grant(par_grant), .id_byte_valid(id_valid), .id_byte(id_byte),
    .id_stored(ID_VAL), .reset_vector(vector), .prog_cmd_valid(prog_valid),
    .prog_cmd_accept(prog_cmd_accept));
  frg_engine_model engine (.clk(clk), .rst(rst), .op_start(op_start), .delay(delay),
    .fail_in(fail_in), .op_done(op_done), .op_fail(op_fail));
  task automatic report_and_stop();
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic prot(input logic [7:0] d, input logic exp);
    wr_reg(frg_pkg::REG_PROTECT, d);
    #1;
    chk(par_grant, exp);
  endtask
  task automatic ext(input logic [19:0] a, input logic exp);
    @(posedge clk);
    ext_addr <= a;
    @(posedge clk);
    #1;
    chk(ext_blocked, exp);
  endtask
  // Issues one command, then waits out any started operation
  task automatic do_cmd(input frg_pkg::frg_cmd_code_type code, input logic [3:0] blk,
    input logic boot, input logic exp);
    logic op;
    op = exp && code <= frg_pkg::CMD_ERASE_ALL;
    @(posedge clk);
    cmd <= '{code, blk, boot};
    cmd_valid <= 1'b1;
    #1;
    chk(cmd_accept, exp);
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk(op_start, op);
    chk(cpu_hold, op && rom_on);
    if (op)
    begin
      chk(op_cmd, {code, blk, boot});
      n = 0;
      while (op_done !== 1'b1 && n < 300)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      @(posedge clk);
      #1;
      chk(cpu_hold, 1'b0);
      chk(read_mode_status, !rom_on);
    end
  endtask
  task automatic send_id(input logic [55:0] v);
    for (int i = 0; i < frg_pkg::ID_BYTES; i++)
    begin
      @(posedge clk);
      id_valid <= 1'b1;
      id_byte <= v[8*i +: 8];
      @(posedge clk);
      id_valid <= 1'b0;
    end
    @(posedge clk);
    #1;
  endtask
  // ****************************************
  // Stimulus
  // ****************************************
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    for (int r = 0; r < 5; r++)
      rd_chk(row_addr[r], row_val[r]);
    wr_reg(frg_pkg::REG_MODE_A, 8'h02);
    rd_chk(frg_pkg::REG_MODE_A, 8'h01);
    do_cmd(frg_pkg::CMD_PROGRAM, 4'h2, 1'b0, 1'b0);
    rd_chk(frg_pkg::REG_MODE_A, 8'h01);
    wr_reg(frg_pkg::REG_MODE_A, 8'h00);
    wr_reg(frg_pkg::REG_MODE_A, 8'h02);
    rd_chk(frg_pkg::REG_MODE_A, 8'h03);
    chk({block_a_en, area_expand}, 2'h3);
    ext(20'h40000, 1'b0);
    prot(8'h3F, 1'b0);
    prot(8'hBF, 1'b0);
    prot(8'hC0, 1'b1);
    prot(8'h00, 1'b1);
    prot(8'h3F, 1'b0);
    do_cmd(frg_pkg::CMD_BLOCK_ERASE, frg_pkg::PROTECT_BLOCK, 1'b0, 1'b1);
    rd_chk(frg_pkg::REG_PROTECT, 8'hFF);
    chk(par_grant, 1'b1);
    par_req <= 1'b0;
    @(posedge clk);
    #1;
    chk(par_grant, 1'b0);
    par_req <= 1'b1;
    fail_in <= 1'b1;
    delay <= 8'h20;
    do_cmd(frg_pkg::CMD_PROGRAM, 4'h2, 1'b0, 1'b1);
    rd_chk(frg_pkg::REG_MODE_A, 8'h43);
    rd_chk(frg_pkg::REG_STATUS, 8'h90);
    do_cmd(frg_pkg::CMD_CLEAR_STATUS, 4'h0, 1'b0, 1'b1);
    rd_chk(frg_pkg::REG_MODE_A, 8'h03);
    fail_in <= 1'b0;
    delay <= 8'h01;
    do_cmd(frg_pkg::CMD_READ_STATUS, 4'h0, 1'b0, 1'b1);
    do_cmd(frg_pkg::CMD_PROGRAM, 4'h2, 1'b1, 1'b0);
    do_cmd(frg_pkg::CMD_BLOCK_ERASE, 4'h2, 1'b1, 1'b0);
    routine_unlocked <= 1'b1;
    do_cmd(frg_pkg::CMD_ERASE_ALL, 4'h0, 1'b0, 1'b1);
    wr_reg(frg_pkg::REG_MODE_B, 8'h50);
    wr_reg(frg_pkg::REG_MODE_B, 8'h52);
    rd_chk(frg_pkg::REG_MODE_B, 8'h52);
    rom_on = 1'b1;
    do_cmd(frg_pkg::CMD_PROGRAM, 4'h5, 1'b0, 1'b0);
    do_cmd(frg_pkg::CMD_BLOCK_ERASE, 4'h5, 1'b0, 1'b0);
    do_cmd(frg_pkg::CMD_ERASE_ALL, 4'h0, 1'b0, 1'b0);
    routine_unlocked <= 1'b0;
    wr_reg(frg_pkg::REG_MODE_A, 8'h06);
    rd_chk(frg_pkg::REG_MODE_A, 8'h07);
    do_cmd(frg_pkg::CMD_ERASE_ALL, 4'h0, 1'b0, 1'b0);
    wr_reg(frg_pkg::REG_MODE_A, 8'h02);
    do_cmd(frg_pkg::CMD_ERASE_ALL, 4'h0, 1'b0, 1'b1);
    do_cmd(frg_pkg::CMD_READ_STATUS, 4'h0, 1'b0, 1'b0);
    rd_chk(frg_pkg::REG_STATUS, 8'h00);
    delay <= 8'h00;
    do_cmd(frg_pkg::CMD_PROGRAM, 4'h3, 1'b0, 1'b1);
    wr_reg(frg_pkg::REG_MODE_A, 8'h00);
    rom_on = 1'b0;
    ext(20'h40000, 1'b1);
    ext(20'h3FFFF, 1'b0);
    ext(20'hBFFFF, 1'b1);
    ext(20'hC0000, 1'b0);
    chk({block_a_en, area_expand}, 2'h0);
    wr_reg(frg_pkg::REG_PROC_B, 8'h09);
    ext(20'h40000, 1'b0);
    chk({block_a_en, area_expand}, 2'h3);
    wr_reg(frg_pkg::REG_PROC_B, 8'h00);
    parallel_pin <= 1'b0;
    serial_pin <= 1'b1;
    large_pin <= 1'b0;
    repeat (6) @(posedge clk);
    ext(20'h40000, 1'b0);
    chk(par_grant, 1'b0);
    send_id(~ID_VAL);
    chk(prog_cmd_accept, 1'b0);
    vector <= frg_pkg::VECTOR_BLANK;
    @(posedge clk);
    #1;
    chk(prog_cmd_accept, 1'b1);
    vector <= 32'h00001234;
    serial_pin <= 1'b0;
    repeat (6) @(posedge clk);
    serial_pin <= 1'b1;
    repeat (6) @(posedge clk);
    send_id(ID_VAL);
    chk(prog_cmd_accept, 1'b1);
    prog_valid <= 1'b0;
    @(posedge clk);
    #1;
    chk(prog_cmd_accept, 1'b0);
    ce <= 1'b0;
    wr_reg(frg_pkg::REG_PROTECT, 8'h3F);
    ce <= 1'b1;
    rd_chk(frg_pkg::REG_PROTECT, 8'hFF);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    for (int r = 0; r < 5; r++)
      rd_chk(row_addr[r], row_val[r]);
    report_and_stop();
  end
endmodule // flash_rewrite_guard_and_cpu_rewrite_tb

// *** sim/frg_engine_model.sv ***
// Purpose: Flash engine stand-in that ends each started operation
// Assumes: One operation at a time, started by a one-cycle pulse
// Notes: Fail line only meaningful beside the done pulse
`timescale 1ns/1ps
module frg_engine_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic op_start,
  input wire logic [7:0] delay,
  input wire logic fail_in,
  output logic op_done,
  output logic op_fail
);
  logic [7:0] count_reg;
  logic busy_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_reg <= 8'h00;
      busy_reg <= 1'b0;
      op_done <= 1'b0;
      op_fail <= 1'b0;
    end
    else
    begin
      op_done <= 1'b0;
      // Toggles away from the done pulse
      op_fail <= ~op_fail;
      if (op_start)
      begin
        busy_reg <= 1'b1;
        count_reg <= delay;
      end
      else if (busy_reg && count_reg == 8'h00)
      begin
        busy_reg <= 1'b0;
        op_done <= 1'b1;
        op_fail <= fail_in;
      end
      else if (busy_reg)
      begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end
endmodule // frg_engine_model
